// >>> design/pcr_map.svh
// register offsets, field positions, reset values and timing figures of the power control register bank
// assumes inclusion by the package and by the design modules of this bank
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH
`define PCR_ADDR_W          8
`define PCR_OFS_SYS_MON     8'h00
`define PCR_OFS_SYS_HIB     8'h01
`define PCR_OFS_B1_VPRI     8'h20
`define PCR_OFS_B1_VSEC     8'h21
`define PCR_OFS_B1_CTRL     8'h22
`define PCR_RST_SYS_MON     8'h47
`define PCR_RST_SYS_HIB     8'h00
`define PCR_RST_B1_VPRI     6'h24
`define PCR_RST_B1_VSEC     6'h20
`define PCR_RST_B1_CTRL     8'h04
`define PCR_MON_TRST        7
`define PCR_MON_ACTION      6
`define PCR_MON_UNMASK      5
`define PCR_MON_LOW         4
`define PCR_MON_THR_HI      3
`define PCR_MON_THR_LO      0
`define PCR_HIB_FORCE       6
`define PCR_HIB_SCR_HI      3
`define PCR_HIB_SCR_LO      2
`define PCR_HIB_READY       1
`define PCR_HIB_SCR0        0
`define PCR_CTL_ON          7
`define PCR_CTL_PHASE       6
`define PCR_CTL_MODE        5
`define PCR_CTL_DLY_HI      4
`define PCR_CTL_DLY_LO      2
`define PCR_CTL_FLT_EN      1
`define PCR_CTL_PGOOD       0
`define PCR_HIB_WMASK       8'h4f
`define PCR_CTL_WMASK       8'hfe
`define PCR_CLK_MHZ         50
`define PCR_TRST_SHORT_MS   65
`define PCR_TRST_LONG_MS    260
`endif

// >>> design/pcr_pkg.sv
// types shared by the power control register bank
// assumes the map header defines all offsets and widths
`include "pcr_map.svh"
package pcr_pkg;
  typedef enum logic [2:0] {
    PCR_ST_HOLD = 3'b001,
    PCR_ST_RUN  = 3'b010,
    PCR_ST_TRIP = 3'b100
  } pcr_mon_st_t;

  typedef struct packed {
    logic [7:0]  mon;
    logic [7:0]  hib;
    logic [5:0]  vpri;
    logic [5:0]  vsec;
    logic [7:0]  ctl;
    logic [7:0]  rdata;
    logic [5:0]  vcode;
    logic        irq;
    logic        shutdown;
    logic        en;
    logic        flt;
    pcr_mon_st_t st;
  } pcr_state_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
  } pcr_tmr_state_t;
endpackage : pcr_pkg

// >>> design/pcr_rst_timer.sv
// reset time-out counter that holds the reset output low after power-good
// assumes start is a level: high while the supply rail is good
`include "pcr_map.svh"
module pcr_rst_timer #(
  parameter int unsigned SHORT_CYC = `PCR_TRST_SHORT_MS * `PCR_CLK_MHZ * 1000,
  parameter int unsigned LONG_CYC  = `PCR_TRST_LONG_MS * `PCR_CLK_MHZ * 1000
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic start,
  input  wire logic sel_short,
  output logic      done_q
);
  pcr_pkg::pcr_tmr_state_t t_q;
  pcr_pkg::pcr_tmr_state_t t_d;
  logic [31:0]             lim;

  assign lim = sel_short ? 32'(SHORT_CYC) : 32'(LONG_CYC);

  always_comb begin
    t_d = t_q;
    if (!start) begin
      // losing power-good restarts the whole time-out
      t_d.cnt  = 32'h0;
      t_d.done = 1'b0;
    end else if (!t_q.done) begin
      if (t_q.cnt + 32'h1 >= lim) begin
        t_d.done = 1'b1;
      end
      t_d.cnt = t_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign done_q = t_q.done;
endmodule : pcr_rst_timer

// >>> design/pcr_regs.sv
// system and first step-down converter register bank of the power controller
// assumes the serial port decoder delivers one-cycle write and read strobes with a byte address;
// reset is the undervoltage lockout, synchronous to clk_sys
`include "pcr_map.svh"

module pcr_regs #(
  parameter int unsigned SHORT_CYC = `PCR_TRST_SHORT_MS * `PCR_CLK_MHZ * 1000,
  parameter int unsigned LONG_CYC  = `PCR_TRST_LONG_MS * `PCR_CLK_MHZ * 1000
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  input  wire logic [`PCR_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wdata,
  output logic      [7:0]             rdata,
  input  wire logic                   supply_below_threshold,
  input  wire logic                   voltage_select_input,
  input  wire logic                   power_hold_input,
  input  wire logic                   hibernate,
  input  wire logic                   buck1_power_good,
  input  wire logic                   buck1_fault,
  output logic                        buck1_enable,
  output logic      [5:0]             buck1_voltage_code,
  output logic                        buck1_phase_invert,
  output logic                        buck1_forced_pwm,
  output logic      [2:0]             buck1_turn_on_delay,
  output logic      [3:0]             supply_detect_threshold,
  output logic                        supply_irq,
  output logic                        fault_irq,
  output logic                        supply_shutdown,
  output logic                        reset_output
);
  pcr_pkg::pcr_state_t s_q;
  pcr_pkg::pcr_state_t s_d;
  logic                tmr_done;

  pcr_rst_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_tmr (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .start     (buck1_power_good),
    .sel_short (s_q.mon[`PCR_MON_TRST]),
    .done_q    (tmr_done)
  );

  always_comb begin
    s_d = s_q;
    // register writes; reserved and read-only bits are masked out
    if (wr_en) begin
      case (addr)
        `PCR_OFS_SYS_MON: begin
          s_d.mon = {wdata[7:5], 1'b0, wdata[3:0]};
        end
        `PCR_OFS_SYS_HIB: begin
          s_d.hib = wdata & `PCR_HIB_WMASK;
        end
        `PCR_OFS_B1_VPRI: begin
          s_d.vpri = wdata[5:0];
        end
        `PCR_OFS_B1_VSEC: begin
          s_d.vsec = wdata[5:0];
        end
        `PCR_OFS_B1_CTRL: begin
          s_d.ctl = wdata & `PCR_CTL_WMASK;
        end
        default: begin
          s_d.rdata = s_q.rdata;
        end
      endcase
    end
    // live status bits overlay the stored ones
    s_d.mon[`PCR_MON_LOW] = supply_below_threshold;
    s_d.ctl[`PCR_CTL_PGOOD] = buck1_power_good;
    if (rd_en) begin
      case (addr)
        `PCR_OFS_SYS_MON: s_d.rdata = s_q.mon;
        `PCR_OFS_SYS_HIB: s_d.rdata = s_q.hib;
        `PCR_OFS_B1_VPRI: s_d.rdata = {2'b00, s_q.vpri};
        `PCR_OFS_B1_VSEC: s_d.rdata = {2'b00, s_q.vsec};
        `PCR_OFS_B1_CTRL: s_d.rdata = s_q.ctl;
        default:          s_d.rdata = 8'h00;
      endcase
    end
    s_d.vcode = voltage_select_input ? s_q.vsec : s_q.vpri;
    s_d.irq = 1'b0;
    s_d.shutdown = 1'b0;
    // supply monitor: action select picks interrupt or automatic shutdown
    case (s_q.st)
      pcr_pkg::PCR_ST_HOLD: begin
        s_d.st = pcr_pkg::PCR_ST_RUN;
      end
      pcr_pkg::PCR_ST_RUN: begin
        if (supply_below_threshold && !s_q.mon[`PCR_MON_ACTION]) begin
          s_d.st = pcr_pkg::PCR_ST_TRIP;
        end
        s_d.irq = supply_below_threshold && s_q.mon[`PCR_MON_ACTION]
                  && s_q.mon[`PCR_MON_UNMASK];
      end
      pcr_pkg::PCR_ST_TRIP: begin
        // shutdown is latched until lockout clears the bank
        s_d.shutdown = 1'b1;
      end
      default: begin
        s_d.st = pcr_pkg::PCR_ST_HOLD;
      end
    endcase
    // force-on keeps the converter alive through hibernate without power hold
    s_d.en = s_q.ctl[`PCR_CTL_ON]
             && (!hibernate || power_hold_input || s_q.hib[`PCR_HIB_FORCE]);
    s_d.flt = buck1_fault && s_q.ctl[`PCR_CTL_FLT_EN];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // lockout returns every bit to its default; hibernate is not a reset, so the ready flag survives
      s_q.mon      <= `PCR_RST_SYS_MON;
      s_q.hib      <= `PCR_RST_SYS_HIB;
      s_q.vpri     <= `PCR_RST_B1_VPRI;
      s_q.vsec     <= `PCR_RST_B1_VSEC;
      s_q.ctl      <= `PCR_RST_B1_CTRL;
      s_q.rdata    <= 8'h00;
      s_q.vcode    <= `PCR_RST_B1_VPRI;
      s_q.irq      <= 1'b0;
      s_q.shutdown <= 1'b0;
      s_q.st       <= pcr_pkg::PCR_ST_HOLD;
      s_q.en       <= 1'b0;
      s_q.flt      <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata                   = s_q.rdata;
  assign buck1_enable            = s_q.en;
  assign buck1_voltage_code      = s_q.vcode;
  assign buck1_phase_invert      = s_q.ctl[`PCR_CTL_PHASE];
  assign buck1_forced_pwm        = s_q.ctl[`PCR_CTL_MODE];
  assign buck1_turn_on_delay     = s_q.ctl[`PCR_CTL_DLY_HI:`PCR_CTL_DLY_LO];
  assign supply_detect_threshold = s_q.mon[`PCR_MON_THR_HI:`PCR_MON_THR_LO];
  assign supply_irq              = s_q.irq;
  assign fault_irq               = s_q.flt;
  assign supply_shutdown         = s_q.shutdown;
  assign reset_output            = tmr_done;
endmodule : pcr_regs

// >>> verification/pcr_regs_props.sv
// port checks of the power control register bank
// assumes binding into pcr_regs on one clock domain
`include "pcr_map.svh"
module pcr_regs_props #(
  parameter int unsigned SHORT_CYC = 10,
  parameter int unsigned LONG_CYC  = 40
) (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   wr_en,
  input wire logic [`PCR_ADDR_W-1:0] addr,
  input wire logic [7:0]             wdata,
  input wire logic [7:0]             rdata,
  input wire logic                   supply_below_threshold,
  input wire logic                   voltage_select_input,
  input wire logic                   buck1_fault,
  input wire logic                   buck1_enable,
  input wire logic [5:0]             buck1_voltage_code,
  input wire logic                   buck1_phase_invert,
  input wire logic                   buck1_forced_pwm,
  input wire logic [2:0]             buck1_turn_on_delay,
  input wire logic [3:0]             supply_detect_threshold,
  input wire logic                   supply_irq,
  input wire logic                   fault_irq,
  input wire logic                   supply_shutdown
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  thr_write_a: assert property (
    wr_en && addr == 8'h00 |=> supply_detect_threshold == $past(wdata[3:0])) else $error("threshold not stored");
  ctl_fields_a: assert property (
    wr_en && addr == 8'h22 |=> {buck1_phase_invert, buck1_forced_pwm, buck1_turn_on_delay} == $past(wdata[6:2]))
    else $error("control fields not stored");
  code_pri_a: assert property (
    wr_en && addr == 8'h20 && !voltage_select_input ##1 !wr_en && !voltage_select_input
    |=> buck1_voltage_code == $past(wdata[5:0], 2)) else $error("primary code not followed");
  code_sec_a: assert property (
    wr_en && addr == 8'h21 && voltage_select_input ##1 !wr_en && voltage_select_input
    |=> buck1_voltage_code == $past(wdata[5:0], 2)) else $error("secondary code not followed");
  off_write_a: assert property (
    wr_en && addr == 8'h22 && !wdata[7] ##1 !wr_en |=> !buck1_enable) else $error("converter not disabled");
  supply_irq_a: assert property (
    !$past(supply_below_threshold) |-> !supply_irq) else $error("supply irq without low supply");
  fault_irq_a: assert property (
    !$past(buck1_fault) |-> !fault_irq) else $error("fault irq without fault");
  shut_hold_a: assert property (
    $past(supply_shutdown) && !$past(reset) |-> supply_shutdown) else $error("shutdown released");
  reset_def_a: assert property (disable iff (1'b0)
    reset |=> rdata == 8'h00 && buck1_voltage_code == 6'h24 && supply_detect_threshold == 4'h7 && !buck1_enable)
    else $error("reset defaults wrong");
endmodule : pcr_regs_props
bind pcr_regs pcr_regs_props #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_props (.*);

// >>> verification/pcr_host_model.sv
// host side of the register port: one-cycle strobes driven just after the rising edge
// assumes rdata is valid one cycle after the read strobe
module pcr_host_model (
  input  wire logic       clk_sys,
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  initial {wr_en, rd_en, addr, wdata} = 18'h0;
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
    @(posedge clk_sys);
    #1;
    q = rdata;
    // idle lines show the inverse so a stale value is never mistaken for a live one
    {wr_en, rd_en, addr, wdata} = {2'b00, ~a, ~d};
  endtask : put
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    put(1'b1, a, d, q);
  endtask : wr
  task automatic hib_enter();
    wr(8'h01, 8'h42);
  endtask : hib_enter
  task automatic hib_wake(output logic [7:0] q);
    put(1'b0, 8'h01, 8'h00, q);
    wr(8'h01, q & 8'hbf);
  endtask : hib_wake
endmodule : pcr_host_model

// >>> verification/tb.sv
// self-checking bench of the power control register bank
// assumes the host model drives the register port; timer counts shortened
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SHORT_N = 10;
  localparam int unsigned LONG_N  = 40;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} pcr_row_t;
  logic       clk_sys = 1'b0, reset = 1'b1, wr_en, rd_en, supply_below_threshold = 1'b0;
  logic       voltage_select_input = 1'b0, power_hold_input = 1'b0, hibernate = 1'b0;
  logic       buck1_power_good = 1'b0, buck1_fault = 1'b0, buck1_enable, buck1_phase_invert;
  logic       buck1_forced_pwm, supply_irq, fault_irq, supply_shutdown, reset_output;
  logic [7:0] addr, wdata, rdata, q;
  logic [5:0] buck1_voltage_code;
  logic [3:0] supply_detect_threshold;
  logic [2:0] buck1_turn_on_delay;
  int         err_count = 0, checked = 0;
  pcr_row_t   rows [11] = '{'{1'b0, 8'h00, 8'h00, 8'h47}, '{1'b0, 8'h01, 8'h00, 8'h00},
    '{1'b0, 8'h20, 8'h00, 8'h24}, '{1'b0, 8'h21, 8'h00, 8'h20}, '{1'b0, 8'h22, 8'h00, 8'h04},
    '{1'b1, 8'h00, 8'hff, 8'hef}, '{1'b1, 8'h01, 8'hff, 8'h4f}, '{1'b1, 8'h20, 8'hff, 8'h3f},
    '{1'b1, 8'h21, 8'hff, 8'h3f}, '{1'b1, 8'h22, 8'hff, 8'hfe}, '{1'b1, 8'h30, 8'hff, 8'h00}};
  always #10 clk_sys = ~clk_sys;
  pcr_regs #(.SHORT_CYC(SHORT_N), .LONG_CYC(LONG_N)) DUT (.*);
  pcr_host_model host (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic print_verdict();
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #100us;
    err_count++;
    print_verdict();
  end
  initial begin
    step(8);
    reset = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) host.wr(rows[i].a, rows[i].d);
      host.put(1'b0, rows[i].a, 8'h00, q);
      chk(q, rows[i].e);
    end
    chk({3'h0, buck1_phase_invert, buck1_forced_pwm, buck1_turn_on_delay}, 8'h1f);
    chk({4'h0, supply_detect_threshold}, 8'h0f);
    voltage_select_input = 1'b1;
    host.wr(8'h21, 8'h2a);
    step(2);
    chk({2'h0, buck1_voltage_code}, 8'h2a);
    voltage_select_input = 1'b0;
    host.wr(8'h20, 8'h15);
    step(2);
    chk({2'h0, buck1_voltage_code}, 8'h15);
    supply_below_threshold = 1'b1;
    host.wr(8'h00, 8'h60);
    step(2);
    chk({7'h0, supply_irq}, 8'h01);
    host.put(1'b0, 8'h00, 8'h00, q);
    chk(q, 8'h70);
    host.wr(8'h00, 8'h40);
    step(2);
    chk({7'h0, supply_irq}, 8'h00);
    host.wr(8'h00, 8'h00);
    step(2);
    chk({7'h0, supply_shutdown}, 8'h01);
    supply_below_threshold = 1'b0;
    step(2);
    chk({7'h0, supply_shutdown}, 8'h01);
    for (int i = 0; i < 2; i++) begin
      buck1_power_good = 1'b0;
      host.wr(8'h00, i ? 8'h80 : 8'h00);
      buck1_power_good = 1'b1;
      step(i ? SHORT_N - 4 : LONG_N - 4);
      chk({7'h0, reset_output}, 8'h00);
      step(8);
      chk({7'h0, reset_output}, 8'h01);
    end
    host.put(1'b0, 8'h22, 8'h00, q);
    chk({7'h0, q[0]}, 8'h01);
    buck1_fault = 1'b1;
    hibernate = 1'b1;
    host.wr(8'h01, 8'h00);
    host.wr(8'h22, 8'h82);
    step(2);
    chk({6'h0, fault_irq, buck1_enable}, 8'h02);
    power_hold_input = 1'b1;
    step(2);
    chk({7'h0, buck1_enable}, 8'h01);
    power_hold_input = 1'b0;
    host.hib_enter();
    step(2);
    chk({7'h0, buck1_enable}, 8'h01);
    hibernate = 1'b0;
    host.hib_wake(q);
    chk({7'h0, q[1]}, 8'h01);
    host.wr(8'h22, 8'h00);
    step(2);
    chk({6'h0, fault_irq, buck1_enable}, 8'h00);
    reset = 1'b1;
    step(3);
    reset = 1'b0;
    host.put(1'b0, 8'h01, 8'h00, q);
    chk(q, 8'h00);
    print_verdict();
  end
endmodule : tb
